// *** hw/adcrc_conv_sync.sv ***
// Converter-clock crossing: carries one conversion result into the bus-clock domain.
`timescale 1ns/10ps
module adcrc_conv_sync #(
    parameter int WIDTH = 10
) (
    input  wire logic             clk,         // Bus clock.
    input  wire logic             sys_rst,     // Asynchronous reset, active high.
    input  wire logic             clk_en,      // Freezes all state while low.
    input  wire logic             async_mode,  // High when the converter runs on its own clock.
    input  wire logic             done_toggle, // Toggles once per finished conversion.
    input  wire logic [WIDTH-1:0] done_data,   // Result, stable while the toggle is settled.
    output logic                  done_pulse,  // One-cycle completion pulse in bus domain.
    output logic      [WIDTH-1:0] done_value   // Result captured with the pulse.
);

    logic             meta_reg;
    logic             meta_next;
    logic             sync_reg;
    logic             sync_next;
    logic             last_reg;
    logic             last_next;
    logic             pulse_reg;
    logic             pulse_next;
    logic [WIDTH-1:0] value_reg;
    logic [WIDTH-1:0] value_next;

    // ==========================================================================
    // Toggle synchroniser
    // ==========================================================================
    // The data word is held by the converter until the next toggle, so it is
    // safe to sample once the synchronised toggle has changed. When the converter
    // runs on the bus clock the two extra flops are bypassed to save latency.
    always_comb begin
        meta_next  = done_toggle;
        sync_next  = meta_reg;
        last_next  = async_mode ? sync_reg : done_toggle;
        pulse_next = last_next != last_reg;
        value_next = pulse_next ? done_data : value_reg;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_reg  <= 1'b0;
            sync_reg  <= 1'b0;
            last_reg  <= 1'b0;
            pulse_reg <= 1'b0;
            value_reg <= '0;
        end else if (clk_en) begin
            meta_reg  <= meta_next;
            sync_reg  <= sync_next;
            last_reg  <= last_next;
            pulse_reg <= pulse_next;
            value_reg <= value_next;
        end
    end

    assign done_pulse = pulse_reg;
    assign done_value = value_reg;

endmodule

// *** hw/adcrc_ctrl.sv ***
// Control and result-coherency logic of the analog-to-digital converter.
`timescale 1ns/10ps
module adcrc_ctrl #(
    parameter int CONV_CYCLES = 20
) (
    input  wire logic       clk,              // Bus clock, 25 MHz.
    input  wire logic       sys_rst,          // Asynchronous reset, active high.
    input  wire logic       clk_en,           // Freezes all state except the converter timing flops while low.
    input  wire logic       ctrl_wr,          // Write pulse to conv_status_control_one.
    input  wire logic [4:0] ctrl_channel,     // Channel field; all ones turns converter off.
    input  wire logic       ctrl_continuous,  // Continuous conversion select.
    input  wire logic       ctrl_int_en,      // Conversion-complete interrupt enable.
    input  wire logic       mode_10bit,       // High for 10-bit, low for 8-bit results.
    input  wire logic       async_clk_sel,    // High when the converter uses its own clock.
    input  wire logic       conv_clk,         // Asynchronous converter clock.
    input  wire logic [9:0] analog_sample,    // Digitised value from the analog core.
    input  wire logic       rd_upper,         // Read pulse of the upper result byte.
    input  wire logic       rd_lower,         // Read pulse of the lower result byte.
    output logic      [7:0] rd_data,          // Read data of the selected byte.
    output logic            conversion_done_flag, // Conversion-complete flag.
    output logic            conv_irq,         // Interrupt request, level.
    output logic            conv_active,      // Converter is converting.
    output logic      [4:0] channel_out       // Channel now being converted.
);

    initial begin
        if (CONV_CYCLES < 2 || CONV_CYCLES > 65535)
            $error("CONV_CYCLES out of range");
    end

    // ==========================================================================
    // Control register
    // ==========================================================================
    logic [4:0] channel_reg;
    logic [4:0] channel_next;
    logic       cont_reg;
    logic       cont_next;
    logic       int_en_reg;
    logic       int_en_next;

    always_comb begin
        channel_next = ctrl_wr ? ctrl_channel    : channel_reg;
        cont_next    = ctrl_wr ? ctrl_continuous : cont_reg;
        int_en_next  = ctrl_wr ? ctrl_int_en     : int_en_reg;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            channel_reg <= adcrc_pkg::CHANNEL_RESET;
            cont_reg    <= 1'b0;
            int_en_reg  <= 1'b0;
        end else if (clk_en) begin
            channel_reg <= channel_next;
            cont_reg    <= cont_next;
            int_en_reg  <= int_en_next;
        end
    end

    // ==========================================================================
    // Converter timing, on conv_clk or on the bus clock
    // ==========================================================================
    // Starts come from the bus domain and are handed to the converter clock as a
    // toggle through a three-flop synchroniser; the clock select is used directly,
    // unsynchronised, as the clock mux select. The converter's own timing is
    // modelled with a cycle counter in the active clock domain.
    logic start_tgl_reg;
    logic start_tgl_next;

    logic [2:0]  c_start_sync;
    logic        c_start_seen;
    logic [15:0] c_cnt;
    logic        c_busy;
    logic        c_done_tgl;
    logic [9:0]  c_data;
    logic        c_tag;
    logic        conv_clock;

    assign conv_clock = async_clk_sel ? conv_clk : clk;

    always_ff @(posedge conv_clock or posedge sys_rst) begin
        if (sys_rst) begin
            c_start_sync <= 3'h0;
            c_start_seen <= 1'b0;
            c_cnt        <= 16'h0000;
            c_busy       <= 1'b0;
            c_done_tgl   <= 1'b0;
            c_data       <= adcrc_pkg::RESULT_RESET;
            c_tag        <= 1'b0;
        end else begin
            c_start_sync <= {c_start_sync[1:0], start_tgl_reg};
            c_start_seen <= c_start_sync[2];
            if (c_start_sync[2] != c_start_seen) begin
                c_busy <= 1'b1;
                c_tag  <= c_start_sync[2];
                c_cnt  <= 16'(CONV_CYCLES - 1);
            end else if (c_busy) begin
                if (c_cnt == 16'h0000) begin
                    c_busy     <= 1'b0;
                    c_data     <= analog_sample;
                    c_done_tgl <= ~c_done_tgl;
                end else begin
                    c_cnt <= c_cnt - 16'h0001;
                end
            end
        end
    end

    logic        done_pulse;
    logic [10:0] done_value;

    adcrc_conv_sync #(
        .WIDTH(adcrc_pkg::RESULT_WIDTH + 1)
    ) u_sync (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .clk_en     (clk_en),
        .async_mode (async_clk_sel),
        .done_toggle(c_done_tgl),
        .done_data  ({c_tag, c_data}),
        .done_pulse (done_pulse),
        .done_value (done_value)
    );

    // ==========================================================================
    // Sequencer
    // ==========================================================================
    // Every result carries the start toggle it answers. A completion that
    // belongs to an older start, or lands with a control write, is dropped,
    // so a write always leaves the flag clear and the old result in place.
    adcrc_pkg::adcrc_state_type state_reg;
    adcrc_pkg::adcrc_state_type state_next;
    logic                       accept;
    logic                       active_reg;
    logic                       active_next;

    assign accept = done_pulse && !ctrl_wr && (done_value[10] == start_tgl_reg)
                    && (state_reg == adcrc_pkg::ADCRC_BUSY);

    always_comb begin
        state_next     = state_reg;
        start_tgl_next = start_tgl_reg;
        if (ctrl_wr) begin
            if (ctrl_channel == adcrc_pkg::CHANNEL_OFF) begin
                state_next = adcrc_pkg::ADCRC_IDLE;
            end else begin
                state_next     = adcrc_pkg::ADCRC_BUSY;
                start_tgl_next = ~start_tgl_reg;
            end
        end else begin
            unique case (state_reg)
                adcrc_pkg::ADCRC_IDLE: begin
                    state_next = adcrc_pkg::ADCRC_IDLE;
                end
                adcrc_pkg::ADCRC_BUSY: begin
                    if (accept)
                        state_next = cont_reg ? adcrc_pkg::ADCRC_CROSS
                                              : adcrc_pkg::ADCRC_IDLE;
                end
                adcrc_pkg::ADCRC_CROSS: begin
                    state_next     = adcrc_pkg::ADCRC_BUSY;
                    start_tgl_next = ~start_tgl_reg;
                end
                default: begin
                    state_next = adcrc_pkg::ADCRC_IDLE;
                end
            endcase
        end
        active_next = state_next != adcrc_pkg::ADCRC_IDLE;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg     <= adcrc_pkg::ADCRC_IDLE;
            start_tgl_reg <= 1'b0;
            active_reg    <= 1'b0;
        end else if (clk_en) begin
            state_reg     <= state_next;
            start_tgl_reg <= start_tgl_next;
            active_reg    <= active_next;
        end
    end

    // ==========================================================================
    // Result register, flag and coherent byte reads
    // ==========================================================================
    // In 8-bit mode the byte is the top eight bits of the result.
    function automatic logic [7:0] lower_byte(input logic [9:0] r, input logic wide);
        return wide ? r[7:0] : r[9:2];
    endfunction

    logic       flag_reg;
    logic       flag_next;
    logic       irq_reg;
    logic       irq_next;
    logic [9:0] result_reg;
    logic [9:0] result_next;
    logic [7:0] hold_reg;
    logic [7:0] hold_next;
    logic       frozen_reg;
    logic       frozen_next;
    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;

    // The hold captures the register as it stood before this edge, so an
    // upper read that meets a landing result still freezes the older byte.
    always_comb begin
        flag_next    = flag_reg;
        result_next  = result_reg;
        hold_next    = hold_reg;
        frozen_next  = frozen_reg;
        rd_data_next = rd_data_reg;
        if (ctrl_wr)
            flag_next = 1'b0;
        if (accept) begin
            flag_next   = 1'b1;
            result_next = done_value[9:0];
        end
        if (rd_upper) begin
            rd_data_next = mode_10bit ? {6'h00, result_reg[9:8]} : 8'h00;
            if (mode_10bit) begin
                hold_next   = lower_byte(result_reg, 1'b1);
                frozen_next = 1'b1;
            end
        end else if (rd_lower) begin
            rd_data_next = (frozen_reg && mode_10bit) ? hold_reg
                                                      : lower_byte(result_reg, mode_10bit);
            frozen_next  = 1'b0;
        end
        irq_next = flag_next && int_en_next;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flag_reg    <= 1'b0;
            irq_reg     <= 1'b0;
            result_reg  <= adcrc_pkg::RESULT_RESET;
            hold_reg    <= 8'h00;
            frozen_reg  <= 1'b0;
            rd_data_reg <= 8'h00;
        end else if (clk_en) begin
            flag_reg    <= flag_next;
            irq_reg     <= irq_next;
            result_reg  <= result_next;
            hold_reg    <= hold_next;
            frozen_reg  <= frozen_next;
            rd_data_reg <= rd_data_next;
        end
    end

    assign rd_data              = rd_data_reg;
    assign conversion_done_flag = flag_reg;
    assign conv_irq             = irq_reg;
    assign conv_active          = active_reg;
    assign channel_out          = channel_reg;

endmodule

// *** hw/adcrc_pkg.sv ***
// Package of constants and types for the converter result-coherency control block.
package adcrc_pkg;

    // ==========================================================================
    // Widths
    // ==========================================================================
    localparam int RESULT_WIDTH  = 10;
    localparam int CHANNEL_WIDTH = 5;

    // ==========================================================================
    // Values after reset, and the channel code that turns the converter off
    // ==========================================================================
    localparam logic [9:0] RESULT_RESET  = 10'h000;
    localparam logic [4:0] CHANNEL_RESET = 5'h1f;
    localparam logic [4:0] CHANNEL_OFF   = 5'h1f;

    // ==========================================================================
    // Converter sequencer states
    // ==========================================================================
    typedef enum logic [2:0] {
        ADCRC_IDLE  = 3'b001,
        ADCRC_BUSY  = 3'b010,
        ADCRC_CROSS = 3'b100
    } adcrc_state_type;

endpackage

// *** verification/adcrc_analog_model.sv ***
// Model of the analog core: free converter clock and a held sample level.
`timescale 1ns/10ps
module adcrc_analog_model (
    input wire logic [9:0] level,         // Level the bench wants converted.
    output logic           conv_clk,      // Converter clock, unrelated to the bus clock.
    output logic     [9:0] analog_sample  // Digitised level.
);
    // ==========================================
    // Core
    // An odd half period keeps the crossing exercised at shifting phases.
    initial conv_clk = 1'b0;
    always #27 conv_clk = ~conv_clk;
    assign analog_sample = level;
endmodule

// *** verification/adcrc_ctrl_chk.sv ***
// Checker of the converter control block's port behaviour.
`timescale 1ns/10ps
module adcrc_ctrl_chk (
    input wire logic       clk,                  // Bus clock.
    input wire logic       sys_rst,              // Reset, active high.
    input wire logic       clk_en,               // Clock enable.
    input wire logic       ctrl_wr,              // Control write pulse.
    input wire logic [4:0] ctrl_channel,         // Channel field.
    input wire logic       ctrl_int_en,          // Interrupt enable.
    input wire logic       conversion_done_flag, // Done flag.
    input wire logic       conv_irq,             // Interrupt request.
    input wire logic       conv_active,          // Converting.
    input wire logic [4:0] channel_out           // Channel in use.
);
    // ==========================================
    // Properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence off_wr; ctrl_wr && ctrl_channel == 5'h1f; endsequence
    sequence quiet_end; $fell(conv_active) && !ctrl_wr && !$past(ctrl_wr); endsequence
    irq_has_flag_a: assert property (conv_irq |-> conversion_done_flag || $past(conversion_done_flag))
        else $error("irq without done flag");
    off_clears_a: assert property (off_wr |-> ##[1:2] !conversion_done_flag)
        else $error("flag kept after write");
    off_stops_a: assert property (off_wr |-> ##[1:3] !conv_active)
        else $error("converter kept running");
    chan_on_write_a: assert property ($changed(channel_out) |-> $past(ctrl_wr) || $past(ctrl_wr, 2))
        else $error("channel changed without write");
    no_irq_a: assert property (ctrl_wr && !ctrl_int_en |-> ##2 !conv_irq)
        else $error("irq while disabled");
    reset_clear_a: assert property ($fell(sys_rst) |-> !conversion_done_flag && !conv_irq)
        else $error("flag set out of reset");
    done_after_a: assert property (quiet_end |-> ##[0:16] conversion_done_flag)
        else $error("conversion ended without flag");
    hold_state_a: assert property (!clk_en |=> $stable(conversion_done_flag) && $stable(channel_out))
        else $error("state moved while disabled");
endmodule
bind adcrc_ctrl adcrc_ctrl_chk u_chk (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .ctrl_wr(ctrl_wr), .ctrl_channel(ctrl_channel), .ctrl_int_en(ctrl_int_en),
    .conversion_done_flag(conversion_done_flag), .conv_irq(conv_irq),
    .conv_active(conv_active), .channel_out(channel_out));

// *** verification/tb_adcrc_ctrl.sv ***
// Self-checking testbench of the converter control block.
`timescale 1ns/10ps
module tb_adcrc_ctrl;
    logic       clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, ctrl_wr = 1'b0, ctrl_continuous = 1'b0;
    logic       ctrl_int_en = 1'b0, mode_10bit = 1'b1, async_clk_sel = 1'b0;
    logic       rd_upper = 1'b0, rd_lower = 1'b0, conv_clk, conversion_done_flag, conv_irq;
    logic       conv_active;
    logic [4:0] ctrl_channel = 5'h1f, channel_out;
    logic [9:0] level = 10'h000, analog_sample;
    logic [7:0] rd_data, d;
    int         n_errors = 0, num_checks = 0;
    always #20 clk = ~clk;
    adcrc_analog_model model (.level(level), .conv_clk(conv_clk), .analog_sample(analog_sample));
    adcrc_ctrl #(.CONV_CYCLES(8)) dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .ctrl_wr(ctrl_wr), .ctrl_channel(ctrl_channel), .ctrl_continuous(ctrl_continuous),
        .ctrl_int_en(ctrl_int_en), .mode_10bit(mode_10bit), .async_clk_sel(async_clk_sel),
        .conv_clk(conv_clk), .analog_sample(analog_sample), .rd_upper(rd_upper),
        .rd_lower(rd_lower), .rd_data(rd_data), .conversion_done_flag(conversion_done_flag),
        .conv_irq(conv_irq), .conv_active(conv_active), .channel_out(channel_out));
    // ==========================================
    // Tasks
    task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [4:0] ch, input logic cont, input logic ie);
        @(posedge clk);
        ctrl_wr <= 1'b1;
        ctrl_channel <= ch;
        ctrl_continuous <= cont;
        ctrl_int_en <= ie;
        @(posedge clk);
        ctrl_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic up);
        @(posedge clk);
        rd_upper <= up;
        rd_lower <= !up;
        @(posedge clk);
        rd_upper <= 1'b0;
        rd_lower <= 1'b0;
        #1 d = rd_data;
    endtask
    task automatic wait_done;
        for (int i = 0; i < 400 && conversion_done_flag !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
    endtask
    task automatic final_report;
        $display("checks %0d, errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ==========================================
    // Tests
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        final_report();
    end
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk) #1;
        check("flag", conversion_done_flag, 1'b0);
        level <= 10'h3c7;
        wr(5'h05, 1'b0, 1'b1);
        check("channel", channel_out, 5'h05);
        wait_done();
        repeat (2) @(posedge clk);
        check("irq", conv_irq, 1'b1);
        rd(1'b1); check("upper", d, 8'h03);
        rd(1'b0); check("lower", d, 8'hc7);
        wr(5'h1f, 1'b0, 1'b0);
        repeat (3) @(posedge clk);
        check("flag", conversion_done_flag, 1'b0);
        level <= 10'h2a5;
        async_clk_sel <= 1'b1;
        wr(5'h03, 1'b1, 1'b1);
        wait_done();
        rd(1'b1); check("upper", d, 8'h02);
        level <= 10'h15a;
        clk_en <= 1'b0;
        repeat (4) @(posedge clk);
        clk_en <= 1'b1;
        repeat (60) @(posedge clk);
        rd(1'b0); check("lower", d, 8'ha5);
        rd(1'b1); check("upper", d, 8'h01);
        rd(1'b0); check("lower", d, 8'h5a);
        wr(5'h1f, 1'b0, 1'b0);
        repeat (4) @(posedge clk);
        check("active", conv_active, 1'b0);
        check("flag", conversion_done_flag, 1'b0);
        mode_10bit <= 1'b0;
        wr(5'h02, 1'b0, 1'b0);
        wait_done();
        check("flag", conversion_done_flag, 1'b1);
        check("irq", conv_irq, 1'b0);
        rd(1'b0); check("byte", d, 8'h56);
        final_report();
    end
endmodule
